// [src/i2c_remap_pkg.sv]
package i2c_remap_pkg;
    // Register indices; byte address is four times the index
    localparam int unsigned IDX_TARGET_BASE = 8;
    localparam int unsigned IDX_TARGET_6 = 14;
    localparam int unsigned IDX_TARGET_7 = 15;
    localparam int unsigned IDX_ALIAS_BASE = 16;
    localparam int unsigned IDX_ALIAS_0 = 16;
    localparam int unsigned IDX_ALIAS_1 = 17;
    localparam int unsigned IDX_ALIAS_2 = 18;
    localparam int unsigned IDX_ALIAS_3 = 19;
    localparam int unsigned NUM_ENTRIES = 8;
    localparam logic [7:0] TARGET_RESET = 8'h00;
    localparam logic [6:0] ALIAS_RESET = 7'h00;
    localparam logic [6:0] ALIAS_DISABLED = 7'h00;
    localparam int unsigned ADDR_FIELD_LSB = 1;
    localparam int unsigned ADDR_FIELD_MSB = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Address phase of a local I2C transaction
    typedef struct packed {
        logic [6:0] addr;
        logic rnw;
    } i2c_hdr_s;

    // Remapped address phase handed to the control channel
    typedef struct packed {
        logic [6:0] addr;
        logic rnw;
        logic [2:0] entry;
    } fwd_hdr_s;
endpackage

// [src/i2c_remote_alias_remapper.sv]
// Function
// - Target registers hold remote 7-bit physical address
// - Alias registers compared against every local address
// - Match on entry n substitutes target n
// - Substitution done before forwarding to channel
// - Alias value zero never matches
// - All alias and target registers reset zero
// - Every target entry remaps like entries six, seven
`timescale 1ns/1ps
module i2c_remote_alias_remapper #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic req_valid,
    input wire i2c_remap_pkg::i2c_hdr_s req_hdr,
    output logic req_ready,
    output logic fwd_valid,
    output i2c_remap_pkg::fwd_hdr_s fwd_hdr,
    input wire logic fwd_ready,
    output logic miss_pulse
);
    localparam int unsigned N = i2c_remap_pkg::NUM_ENTRIES;

    logic [7:0] target_ff [N];
    logic [7:0] nxt_target [N];
    logic [6:0] alias_ff [N];
    logic [6:0] nxt_alias [N];
    logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
    logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
    logic [7:0] wdata_ff, nxt_wdata;
    logic wstrb0_ff, nxt_wstrb0;
    logic bvalid_ff, nxt_bvalid;
    logic [1:0] bresp_ff, nxt_bresp;
    logic rvalid_ff, nxt_rvalid;
    logic [1:0] rresp_ff, nxt_rresp;
    logic [7:0] rdata_ff, nxt_rdata;
    logic fwd_valid_ff, nxt_fwd_valid;
    i2c_remap_pkg::fwd_hdr_s fwd_hdr_ff, nxt_fwd_hdr;
    logic miss_ff, nxt_miss;
    logic [N-1:0] match_vec;
    logic hit;
    logic [2:0] hit_idx;
    logic do_write;
    logic req_take;
    logic [ADDR_W-3:0] widx, ridx;

    assign s_axi_awready = !aw_got_ff && !bvalid_ff;
    assign s_axi_wready = !w_got_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp = rresp_ff;
    assign s_axi_rdata = {24'h00_0000, rdata_ff};
    assign req_ready = !fwd_valid_ff || fwd_ready;
    assign fwd_valid = fwd_valid_ff;
    assign fwd_hdr = fwd_hdr_ff;
    assign miss_pulse = miss_ff;
    assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
    assign req_take = req_valid && req_ready;
    assign widx = awaddr_ff[ADDR_W-1:2];
    assign ridx = s_axi_araddr[ADDR_W-1:2];

    // Alias decoder, one comparator per entry
    for (genvar g = 0; g < N; g++) begin : g_match
        assign match_vec[g] = (alias_ff[g] != i2c_remap_pkg::ALIAS_DISABLED)
            && (alias_ff[g] == req_hdr.addr);
    end

    // Lowest matching entry wins when software programs duplicates
    always_comb begin
        hit = 1'b0;
        hit_idx = 3'h0;
        for (int i = N - 1; i >= 0; i--) begin
            if (match_vec[i]) begin
                hit = 1'b1;
                hit_idx = 3'(i);
            end
        end
    end

    // AXI write channel capture and response
    always_comb begin
        nxt_aw_got = aw_got_ff;
        nxt_awaddr = awaddr_ff;
        nxt_w_got = w_got_ff;
        nxt_wdata = wdata_ff;
        nxt_wstrb0 = wstrb0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        nxt_target = target_ff;
        nxt_alias = alias_ff;
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_aw_got = 1'b1;
            nxt_awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_w_got = 1'b1;
            nxt_wdata = s_axi_wdata[7:0];
            nxt_wstrb0 = s_axi_wstrb[0];
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
        if (do_write) begin
            nxt_aw_got = 1'b0;
            nxt_w_got = 1'b0;
            nxt_bvalid = 1'b1;
            nxt_bresp = i2c_remap_pkg::RESP_OKAY;
            if (awaddr_ff[1:0] != 2'h0) begin
                nxt_bresp = i2c_remap_pkg::RESP_SLVERR;
            end else if (widx >= (ADDR_W-2)'(i2c_remap_pkg::IDX_TARGET_BASE)
                    && widx < (ADDR_W-2)'(i2c_remap_pkg::IDX_TARGET_BASE + N)) begin
                if (wstrb0_ff) begin
                    nxt_target[3'(widx)] = wdata_ff;
                end
            end else if (widx >= (ADDR_W-2)'(i2c_remap_pkg::IDX_ALIAS_BASE)
                    && widx < (ADDR_W-2)'(i2c_remap_pkg::IDX_ALIAS_BASE + N)) begin
                if (wstrb0_ff) begin
                    nxt_alias[3'(widx)] = wdata_ff[7:1];
                end
            end else begin
                nxt_bresp = i2c_remap_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff <= 1'b0;
            awaddr_ff <= '0;
            w_got_ff <= 1'b0;
            wdata_ff <= 8'h00;
            wstrb0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= i2c_remap_pkg::RESP_OKAY;
            for (int i = 0; i < N; i++) begin
                target_ff[i] <= i2c_remap_pkg::TARGET_RESET;
                alias_ff[i] <= i2c_remap_pkg::ALIAS_RESET;
            end
        end else begin
            aw_got_ff <= nxt_aw_got;
            awaddr_ff <= nxt_awaddr;
            w_got_ff <= nxt_w_got;
            wdata_ff <= nxt_wdata;
            wstrb0_ff <= nxt_wstrb0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            target_ff <= nxt_target;
            alias_ff <= nxt_alias;
        end
    end

    // AXI read channel; alias bit 0 reads as zero
    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = 8'h00;
            nxt_rresp = i2c_remap_pkg::RESP_OKAY;
            if (s_axi_araddr[1:0] != 2'h0) begin
                nxt_rresp = i2c_remap_pkg::RESP_SLVERR;
            end else if (ridx >= (ADDR_W-2)'(i2c_remap_pkg::IDX_TARGET_BASE)
                    && ridx < (ADDR_W-2)'(i2c_remap_pkg::IDX_TARGET_BASE + N)) begin
                nxt_rdata = target_ff[3'(ridx)];
            end else if (ridx >= (ADDR_W-2)'(i2c_remap_pkg::IDX_ALIAS_BASE)
                    && ridx < (ADDR_W-2)'(i2c_remap_pkg::IDX_ALIAS_BASE + N)) begin
                nxt_rdata = {alias_ff[3'(ridx)], 1'b0};
            end else begin
                nxt_rresp = i2c_remap_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 8'h00;
            rresp_ff <= i2c_remap_pkg::RESP_OKAY;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
        end
    end

    // Remap stage: address is swapped before the channel ever sees it
    always_comb begin
        nxt_fwd_valid = fwd_valid_ff;
        nxt_fwd_hdr = fwd_hdr_ff;
        nxt_miss = 1'b0;
        if (fwd_valid_ff && fwd_ready) begin
            nxt_fwd_valid = 1'b0;
        end
        if (req_take) begin
            if (hit) begin
                nxt_fwd_valid = 1'b1;
                nxt_fwd_hdr.addr = target_ff[hit_idx][7:1];
                nxt_fwd_hdr.rnw = req_hdr.rnw;
                nxt_fwd_hdr.entry = hit_idx;
            end else begin
                nxt_miss = 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fwd_valid_ff <= 1'b0;
            fwd_hdr_ff <= '0;
            miss_ff <= 1'b0;
        end else begin
            fwd_valid_ff <= nxt_fwd_valid;
            fwd_hdr_ff <= nxt_fwd_hdr;
            miss_ff <= nxt_miss;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_reset_zero;
        $past(!aresetn) |-> (alias_ff[0] == 7'h00) && (target_ff[7] == 8'h00) && !fwd_valid;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("registers not zero after reset");

    property p_remap;
        req_take && hit |=> fwd_valid && (fwd_hdr.addr == $past(target_ff[hit_idx][7:1]))
            && (fwd_hdr.entry == $past(hit_idx)) && (fwd_hdr.rnw == $past(req_hdr.rnw));
    endproperty
    a_remap: assert property (p_remap) else $error("forwarded address not substituted");

    property p_hold;
        fwd_valid && !fwd_ready |=> fwd_valid && $stable(fwd_hdr);
    endproperty
    a_hold: assert property (p_hold) else $error("forwarded header changed while stalled");

    property p_miss;
        req_take && !hit |=> miss_pulse ##1 !miss_pulse || $past(req_take && !hit);
    endproperty
    a_miss: assert property (p_miss) else $error("unmatched request not reported");

    property p_no_fwd_on_miss;
        req_take && !hit && (!fwd_valid || fwd_ready) |=> !fwd_valid;
    endproperty
    a_no_fwd_on_miss: assert property (p_no_fwd_on_miss) else $error("unmatched request forwarded");

    property p_zero_alias;
        req_valid && (req_hdr.addr == 7'h00) |-> !hit;
    endproperty
    a_zero_alias: assert property (p_zero_alias) else $error("zero alias matched");

    property p_alias_read;
        s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_W'(4 * i2c_remap_pkg::IDX_ALIAS_2))
            |=> s_axi_rvalid && (s_axi_rdata == {24'h00_0000, $past(alias_ff[2]), 1'b0});
    endproperty
    a_alias_read: assert property (p_alias_read) else $error("alias readback wrong");

    property p_target_write;
        do_write && wstrb0_ff && (awaddr_ff == ADDR_W'(4 * i2c_remap_pkg::IDX_TARGET_6))
            |=> s_axi_bvalid && (target_ff[6] == $past(wdata_ff));
    endproperty
    a_target_write: assert property (p_target_write) else $error("target write lost");

    property p_target_read;
        s_axi_arvalid && s_axi_arready
            && (s_axi_araddr == ADDR_W'(4 * (i2c_remap_pkg::IDX_TARGET_BASE + 3)))
            |=> s_axi_rvalid && (s_axi_rdata[7:0] == $past(target_ff[3]));
    endproperty
    a_target_read: assert property (p_target_read) else $error("target 3 readback wrong");
endmodule

// [testbench/remote_channel_model.sv]
`timescale 1ns/1ps
// Far end of the control channel: takes remapped headers, can stall on command
module remote_channel_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic fwd_valid,
    input wire i2c_remap_pkg::fwd_hdr_s fwd_hdr,
    output logic fwd_ready,
    output i2c_remap_pkg::fwd_hdr_s got_hdr,
    output logic [7:0] got_cnt
);
    assign fwd_ready = !stall;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            got_hdr <= '0;
            got_cnt <= 8'h00;
        end else if (fwd_valid && fwd_ready) begin
            got_hdr <= fwd_hdr;
            got_cnt <= got_cnt + 8'h01;
        end
    end
endmodule

// [testbench/tb.sv]
`timescale 1ns/1ps
module tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, req_valid, req_ready;
    logic fwd_valid, fwd_ready, miss_pulse, stall;
    logic [7:0] awaddr, araddr, got_cnt;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    i2c_remap_pkg::i2c_hdr_s req_hdr;
    i2c_remap_pkg::fwd_hdr_s fwd_hdr, got_hdr, e;
    int error_cnt, checks, i;
    i2c_remote_alias_remapper i2c_remote_alias_remapper_i (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .req_valid(req_valid),
        .req_hdr(req_hdr), .req_ready(req_ready), .fwd_valid(fwd_valid),
        .fwd_hdr(fwd_hdr), .fwd_ready(fwd_ready), .miss_pulse(miss_pulse));
    remote_channel_model remote_channel_model_i (.aclk(aclk), .aresetn(aresetn),
        .stall(stall), .fwd_valid(fwd_valid), .fwd_hdr(fwd_hdr), .fwd_ready(fwd_ready),
        .got_hdr(got_hdr), .got_cnt(got_cnt));
    function automatic logic [7:0] tgt(input int n);
        return 8'(8'h41 + 3 * n);
    endfunction
    function automatic logic [6:0] al(input int n);
        return 7'(7'h20 + n);
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bump(inout int n);
        n++;
        if (n > 64) begin
            error_cnt++;
            $display("wait ran out of cycles");
            give_verdict();
        end
    endtask
    task automatic wr(input int idx, input logic [7:0] v, input logic [1:0] er);
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 0;
        w_ok = 0;
        @(posedge aclk);
        awaddr <= 8'(idx * 4);
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            bump(n);
            if (awvalid && awready) begin
                aw_ok = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1;
                wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge aclk);
            bump(n);
        end while (!bvalid);
        bready <= 1'b0;
        chk("bresp", 32'(bresp), 32'(er));
    endtask
    task automatic rd(input int idx, output logic [31:0] v, output logic [1:0] rr);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= 8'(idx * 4);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            bump(n);
        end while (!arready);
        arvalid <= 1'b0;
        do begin
            @(posedge aclk);
            bump(n);
        end while (!rvalid);
        rready <= 1'b0;
        v = rdata;
        rr = rresp;
    endtask
    // Offers one address phase and checks the answer just after the taking edge
    task automatic send(input logic [6:0] a, input logic rnw, input logic hit,
            input i2c_remap_pkg::fwd_hdr_s x);
        int n;
        n = 0;
        @(posedge aclk);
        req_valid <= 1'b1;
        req_hdr <= '{addr: a, rnw: rnw};
        do begin
            @(posedge aclk);
            bump(n);
        end while (!req_ready);
        req_valid <= 1'b0;
        #1;
        chk("fwd_valid", 32'(fwd_valid), 32'(hit));
        chk("miss_pulse", 32'(miss_pulse), 32'(!hit));
        if (hit) begin
            chk("fwd_hdr", 32'(fwd_hdr), 32'(x));
        end
    endtask
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end
    initial begin
        error_cnt = 0;
        checks = 0;
        {aresetn, awvalid, wvalid, bready, arvalid, rready, req_valid, stall} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'h1;
        req_hdr = '0;
        e = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 8; i < 24; i++) begin
            rd(i, d, r);
            chk("reset value", d, 32'h0);
            chk("reset resp", 32'(r), 32'(i2c_remap_pkg::RESP_OKAY));
        end
        send(7'h00, 1'b0, 1'b0, e);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            wr(i2c_remap_pkg::IDX_TARGET_BASE + i, tgt(i), i2c_remap_pkg::RESP_OKAY);
            wr(i2c_remap_pkg::IDX_ALIAS_BASE + i, {al(i), 1'b1}, i2c_remap_pkg::RESP_OKAY);
            rd(i2c_remap_pkg::IDX_TARGET_BASE + i, d, r);
            chk("target", d, {24'h0, tgt(i)});
            rd(i2c_remap_pkg::IDX_ALIAS_BASE + i, d, r);
            chk("alias", d, {24'h0, al(i), 1'b0});
        end
        $display("test program done");
        for (i = 0; i < 8; i++) begin
            e = '{addr: 7'(tgt(i) >> 1), rnw: i[0], entry: i[2:0]};
            send(al(i), i[0], 1'b1, e);
        end
        @(posedge aclk);
        #1;
        chk("forwarded", 32'(got_cnt), 32'h8);
        chk("last header", 32'(got_hdr), 32'(e));
        $display("test remap done");
        send(7'h7f, 1'b0, 1'b0, e);
        wr(i2c_remap_pkg::IDX_ALIAS_3, 8'h00, i2c_remap_pkg::RESP_OKAY);
        send(al(3), 1'b1, 1'b0, e);
        chk("no forward", 32'(got_cnt), 32'h8);
        // Duplicate alias: the lower entry must win
        wr(i2c_remap_pkg::IDX_ALIAS_BASE + 5, {al(1), 1'b0}, i2c_remap_pkg::RESP_OKAY);
        e = '{addr: 7'(tgt(1) >> 1), rnw: 1'b1, entry: 3'h1};
        send(al(1), 1'b1, 1'b1, e);
        $display("test miss done");
        @(posedge aclk);
        stall <= 1'b1;
        e = '{addr: 7'(tgt(6) >> 1), rnw: 1'b0, entry: 3'h6};
        send(al(6), 1'b0, 1'b1, e);
        repeat (3) @(posedge aclk);
        #1;
        chk("held valid", 32'(fwd_valid), 32'h1);
        chk("req_ready", 32'(req_ready), 32'h0);
        chk("held header", 32'(fwd_hdr), 32'(e));
        @(posedge aclk);
        stall <= 1'b0;
        @(posedge aclk);
        #1;
        chk("stalled header", 32'(got_hdr), 32'(e));
        chk("released", 32'(fwd_valid), 32'h0);
        chk("stall count", 32'(got_cnt), 32'ha);
        $display("test stall done");
        wr(30, 8'h55, i2c_remap_pkg::RESP_SLVERR);
        rd(30, d, r);
        chk("unmapped resp", 32'(r), 32'(i2c_remap_pkg::RESP_SLVERR));
        chk("unmapped data", d, 32'h0);
        // Byte lane 0 masked: answer OKAY, register untouched
        @(posedge aclk);
        wstrb <= 4'h0;
        wr(i2c_remap_pkg::IDX_TARGET_6, 8'h99, i2c_remap_pkg::RESP_OKAY);
        rd(i2c_remap_pkg::IDX_TARGET_6, d, r);
        chk("masked write", d, {24'h0, tgt(6)});
        $display("test unmapped done");
        give_verdict();
    end
endmodule
